// file: fmfc_pkg.sv
// Package of constants for the flyback mode and fault control block
package fmfc_pkg;
  localparam int CLK_HZ = 40000000;
  // Jitter square wave
  localparam int JITTER_HZ = 9000;
  localparam int JITTER_HALF_CYC = CLK_HZ / (2 * JITTER_HZ);
  localparam int JITTER_PCT = 5;
  localparam int PCT_FULL = 100;
  // Overvoltage trips needed in a row
  localparam int OVP_TRIPS = 4;
  localparam logic [2:0] OVP_CNT_RESET = 3'h0;
  // Threshold width
  localparam int THR_W = 10;
  typedef enum logic [1:0] {
    FMFC_OFF, FMFC_RUN, FMFC_BURST, FMFC_FAULT
  } fmfc_state_t;
endpackage

// file: fmfc_sync.sv
// Two flip-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module fmfc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          stage1[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule

// file: fmfc_jitter.sv
// Square wave jitter source and threshold offset
`timescale 1ns/10ps
module fmfc_jitter #(
  parameter int HALF_CYC = fmfc_pkg::JITTER_HALF_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Threshold in, reduced threshold out
  input wire logic [fmfc_pkg::THR_W-1:0] thr_in,
  output logic [fmfc_pkg::THR_W-1:0] thr_out,
  output logic phase
);
  logic [15:0] count;
  logic [fmfc_pkg::THR_W+6:0] scaled;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count <= 16'h0000;
      phase <= 1'b0;
    end else if (count == 16'(HALF_CYC - 1)) begin
      count <= 16'h0000;
      phase <= ~phase;
    end else begin
      count <= count + 16'h0001;
    end
  end

  // Depth is a fraction of the amplitude, so it fades at light load
  always_comb begin
    scaled = ({7'h00, thr_in} * 17'(fmfc_pkg::JITTER_PCT)) / 17'(fmfc_pkg::PCT_FULL);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      thr_out <= '0;
    end else if (phase) begin
      thr_out <= thr_in - scaled[fmfc_pkg::THR_W-1:0];
    end else begin
      thr_out <= thr_in;
    end
  end
endmodule

// file: fmfc_top.sv
// Mode and fault control logic of a quasi-resonant flyback controller
// Summary of operation
// - On-time ends at lower of two limits
// - Sensed current crossing threshold turns switch off
// - Feedback 65 mV under entry enters burst
// - Burst resumes switching at burst entry level
// - Burst cycles use fixed internal clamp peak
// - Low feedback selects lowered lockout threshold
// - Above burst exit restores normal lockout threshold
// - Lockout holds gate output low
// - 9 kHz square wave, 5% threshold jitter
// - Demag sample above 2.5 V flags trip
// - Four consecutive trips stop switching
// - Cycle without trip clears trip counter
// - Build option picks auto-restart or latch
// - Auto-restart waits restart level then turn-on
// - Latched fault cycles start-up generator periodically
// - Latch clears on mains removal plus restart
// - Line-dependent offset added to sense signal
// - Armed demag falling edge turns switch on
// - Latched stays off until hv and supply low
`timescale 1ns/10ps
module fmfc_top #(
  parameter bit LATCHED = 1'b0,
  parameter int JITTER_HALF = fmfc_pkg::JITTER_HALF_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Analog comparators
  input wire logic fb_below_entry_cmp,
  input wire logic fb_at_entry_cmp,
  input wire logic fb_above_exit_cmp,
  input wire logic demag_arm_cmp,
  input wire logic demag_fall_cmp,
  input wire logic demag_ovp_cmp,
  input wire logic current_trip_cmp,
  // Supply flags
  input wire logic supply_lockout_cmp,
  input wire logic supply_restart_cmp,
  input wire logic supply_turnon_cmp,
  input wire logic hv_start_cmp,
  // Thresholds from the analog front end
  input wire logic [fmfc_pkg::THR_W-1:0] feedback_thr,
  input wire logic [fmfc_pkg::THR_W-1:0] cc_limit_level,
  input wire logic [fmfc_pkg::THR_W-1:0] burst_clamp_level,
  input wire logic [fmfc_pkg::THR_W-1:0] line_offset,
  // Outputs
  output logic gate_out,
  output logic [fmfc_pkg::THR_W-1:0] peak_threshold,
  output logic [fmfc_pkg::THR_W-1:0] sense_offset,
  output logic lowered_lockout_sel,
  output logic hv_start_enable,
  output logic fault_active,
  output logic burst_active
);
  localparam int NS = 11;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  logic fb_below, fb_at, fb_above, arm_in, fall_in, ovp_in, trip_in;
  logic uvlo, below_restart, turnon, hv_ok;
  logic armed, fall_q, restart_seen, next_gate;
  logic ovp_cycle;
  logic [2:0] ovp_count;
  logic [fmfc_pkg::THR_W-1:0] base_thr;
  logic [fmfc_pkg::THR_W-1:0] jit_thr;
  logic jit_phase;
  fmfc_pkg::fmfc_state_t state;
  fmfc_pkg::fmfc_state_t next_state;

  assign raw = {fb_below_entry_cmp, fb_at_entry_cmp, fb_above_exit_cmp, demag_arm_cmp, demag_fall_cmp,
                demag_ovp_cmp, current_trip_cmp, supply_lockout_cmp, supply_restart_cmp,
                supply_turnon_cmp, hv_start_cmp};

  // Every asynchronous level passes two flops first
  fmfc_sync #(.WIDTH(NS)) u_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .async_in(raw),
    .sync_out(syn)
  );

  assign {fb_below, fb_at, fb_above, arm_in, fall_in, ovp_in, trip_in, uvlo, below_restart, turnon, hv_ok} = syn;

  // Smaller of the two limits governs, clamp replaces both in burst
  always_comb begin
    if (state == fmfc_pkg::FMFC_BURST) begin
      base_thr = burst_clamp_level;
    end else if (cc_limit_level < feedback_thr) begin
      base_thr = cc_limit_level;
    end else begin
      base_thr = feedback_thr;
    end
  end

  fmfc_jitter #(.HALF_CYC(JITTER_HALF)) u_jitter (
    .ref_clk(ref_clk),
    .reset(reset),
    .thr_in(base_thr),
    .thr_out(jit_thr),
    .phase(jit_phase)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      peak_threshold <= '0;
      sense_offset <= '0;
    end else begin
      peak_threshold <= jit_thr;
      sense_offset <= line_offset;
    end
  end

  // Mode and fault state
  always_comb begin
    next_state = state;
    case (state)
      fmfc_pkg::FMFC_OFF: begin
        if (turnon && !uvlo) begin
          next_state = fmfc_pkg::FMFC_RUN;
        end
      end
      fmfc_pkg::FMFC_RUN: begin
        if (uvlo) begin
          next_state = fmfc_pkg::FMFC_OFF;
        end else if (ovp_count == 3'(fmfc_pkg::OVP_TRIPS)) begin
          next_state = fmfc_pkg::FMFC_FAULT;
        end else if (fb_below) begin
          next_state = fmfc_pkg::FMFC_BURST;
        end
      end
      fmfc_pkg::FMFC_BURST: begin
        if (uvlo) begin
          next_state = fmfc_pkg::FMFC_OFF;
        end else if (ovp_count == 3'(fmfc_pkg::OVP_TRIPS)) begin
          next_state = fmfc_pkg::FMFC_FAULT;
        end else if (fb_above) begin
          next_state = fmfc_pkg::FMFC_RUN;
        end
      end
      fmfc_pkg::FMFC_FAULT: begin
        if (!LATCHED && restart_seen && turnon) begin
          next_state = fmfc_pkg::FMFC_OFF;
        end else if (LATCHED && below_restart && !hv_ok) begin
          next_state = fmfc_pkg::FMFC_OFF;
        end
      end
      default: next_state = fmfc_pkg::FMFC_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= fmfc_pkg::FMFC_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Auto-restart needs a dip below restart before turn-on counts
  always_ff @(posedge ref_clk) begin
    if (reset || state != fmfc_pkg::FMFC_FAULT) begin
      restart_seen <= 1'b0;
    end else if (below_restart) begin
      restart_seen <= 1'b1;
    end
  end

  // Burst pause: switching held off until feedback climbs back
  always_ff @(posedge ref_clk) begin
    if (reset || below_restart) begin
      burst_active <= 1'b0;
    end else if (state == fmfc_pkg::FMFC_BURST && fb_below) begin
      burst_active <= 1'b1;
    end else if (fb_at || state != fmfc_pkg::FMFC_BURST) begin
      burst_active <= 1'b0;
    end
  end

  // Adaptive lockout threshold select
  always_ff @(posedge ref_clk) begin
    if (reset || below_restart) begin
      lowered_lockout_sel <= 1'b0;
    end else if (fb_below) begin
      lowered_lockout_sel <= 1'b1;
    end else if (fb_above) begin
      lowered_lockout_sel <= 1'b0;
    end
  end

  // Valley trigger arming; blanked while the switch is on
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      armed <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      fall_q <= fall_in;
      if (gate_out) begin
        armed <= 1'b0;
      end else if (arm_in) begin
        armed <= 1'b1;
      end
    end
  end

  // Gate drive
  always_comb begin
    next_gate = gate_out;
    if (gate_out && trip_in) begin
      next_gate = 1'b0;
    end else if (!gate_out && armed && fall_in && !fall_q) begin
      next_gate = 1'b1;
    end
    if (uvlo || burst_active || state == fmfc_pkg::FMFC_OFF || state == fmfc_pkg::FMFC_FAULT) begin
      next_gate = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      gate_out <= 1'b0;
    end else begin
      gate_out <= next_gate;
    end
  end

  // One sample per valley event, taken at the demag instant
  assign ovp_cycle = !gate_out && armed && fall_in && !fall_q;

  always_ff @(posedge ref_clk) begin
    if (reset || below_restart) begin
      ovp_count <= fmfc_pkg::OVP_CNT_RESET;
    end else if (ovp_cycle) begin
      if (!ovp_in) begin
        ovp_count <= fmfc_pkg::OVP_CNT_RESET;
      end else if (ovp_count != 3'(fmfc_pkg::OVP_TRIPS)) begin
        ovp_count <= ovp_count + 3'h1;
      end
    end
  end

  // Latched variant recycles supply through start-up generator
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hv_start_enable <= 1'b0;
      fault_active <= 1'b0;
    end else begin
      fault_active <= (next_state == fmfc_pkg::FMFC_FAULT);
      if (next_state == fmfc_pkg::FMFC_FAULT && LATCHED) begin
        hv_start_enable <= uvlo ? 1'b1 : (turnon ? 1'b0 : hv_start_enable);
      end else begin
        hv_start_enable <= (next_state == fmfc_pkg::FMFC_OFF || next_state == fmfc_pkg::FMFC_FAULT) && !turnon;
      end
    end
  end

  // Gate may never be high while lockout is seen
  a_gate_lockout: assert property (@(posedge ref_clk) disable iff (reset) uvlo |=> !gate_out)
    else $error("gate high during lockout");
  a_off_gate: assert property (@(posedge ref_clk) disable iff (reset)
    state == fmfc_pkg::FMFC_OFF |=> !gate_out)
    else $error("switching while off");
  a_trip_off: assert property (@(posedge ref_clk) disable iff (reset)
    (gate_out && trip_in) |=> !gate_out)
    else $error("switch not turned off on trip");

  // Valley event, and the states in which it may start a cycle
  sequence s_valley;
    !gate_out && armed && fall_in && !fall_q;
  endsequence
  sequence s_may_switch;
    (state == fmfc_pkg::FMFC_RUN || state == fmfc_pkg::FMFC_BURST) && !uvlo && !burst_active;
  endsequence
  a_valley_turnon: assert property (@(posedge ref_clk) disable iff (reset)
    s_valley ##0 s_may_switch |=> gate_out)
    else $error("valley did not start a cycle");
  a_arm_blank: assert property (@(posedge ref_clk) disable iff (reset)
    gate_out |=> !armed)
    else $error("trigger armed while switch on");
  a_no_unarmed: assert property (@(posedge ref_clk) disable iff (reset)
    (!gate_out && !armed) |=> !gate_out)
    else $error("turn-on without arming");

  // Burst pause and lockout threshold select
  a_burst_entry: assert property (@(posedge ref_clk) disable iff (reset)
    (state == fmfc_pkg::FMFC_RUN && fb_below && !uvlo && ovp_count != 3'(fmfc_pkg::OVP_TRIPS))
    |=> state == fmfc_pkg::FMFC_BURST)
    else $error("burst not entered");
  a_burst_hold: assert property (@(posedge ref_clk) disable iff (reset)
    burst_active |=> !gate_out)
    else $error("switching during burst pause");
  a_burst_resume: assert property (@(posedge ref_clk) disable iff (reset)
    (burst_active && fb_at && !fb_below && !below_restart) |=> !burst_active)
    else $error("burst pause not released");
  a_burst_clamp: assert property (@(posedge ref_clk) disable iff (reset)
    state == fmfc_pkg::FMFC_BURST |-> base_thr == burst_clamp_level)
    else $error("burst does not use clamp");
  a_lowered_sel: assert property (@(posedge ref_clk) disable iff (reset)
    (fb_below && !below_restart) |=> lowered_lockout_sel)
    else $error("lowered threshold not chosen");
  a_lowered_exit: assert property (@(posedge ref_clk) disable iff (reset)
    (fb_above && !fb_below) |=> !lowered_lockout_sel)
    else $error("normal threshold not restored");
  a_restart_clear: assert property (@(posedge ref_clk) disable iff (reset)
    below_restart |=> (ovp_count == 3'h0 && !lowered_lockout_sel && !burst_active))
    else $error("restart did not clear state");

  // Overvoltage sample counting; a lone clean cycle must restart the count
  sequence s_overvolt_sample;
    ovp_in && !below_restart && ovp_count != 3'(fmfc_pkg::OVP_TRIPS);
  endsequence
  a_count_step: assert property (@(posedge ref_clk) disable iff (reset)
    s_valley ##0 s_overvolt_sample |=> ovp_count == $past(ovp_count) + 3'h1)
    else $error("trip not counted");
  a_count_clear: assert property (@(posedge ref_clk) disable iff (reset)
    (ovp_cycle && !ovp_in) |=> ovp_count == 3'h0)
    else $error("trip counter not cleared");
  a_fault_count: assert property (@(posedge ref_clk) disable iff (reset)
    (state == fmfc_pkg::FMFC_RUN && ovp_count == 3'(fmfc_pkg::OVP_TRIPS) && !uvlo)
    |=> state == fmfc_pkg::FMFC_FAULT)
    else $error("no fault after four trips");
  a_fault_no_gate: assert property (@(posedge ref_clk) disable iff (reset)
    state == fmfc_pkg::FMFC_FAULT |=> !gate_out)
    else $error("switching during fault");

  // Recovery: auto-restart needs the supply dip, latch needs mains gone too
  a_auto_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!LATCHED && state == fmfc_pkg::FMFC_FAULT && !restart_seen) |=> state == fmfc_pkg::FMFC_FAULT)
    else $error("auto fault left before supply dip");
  a_auto_exit: assert property (@(posedge ref_clk) disable iff (reset)
    (!LATCHED && state == fmfc_pkg::FMFC_FAULT && restart_seen && turnon) |=> state == fmfc_pkg::FMFC_OFF)
    else $error("auto fault did not restart");
  a_latch_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (LATCHED && state == fmfc_pkg::FMFC_FAULT && !below_restart) |=> state == fmfc_pkg::FMFC_FAULT)
    else $error("latched fault left early");
  a_latch_exit: assert property (@(posedge ref_clk) disable iff (reset)
    (LATCHED && state == fmfc_pkg::FMFC_FAULT && below_restart && !hv_ok) |=> state == fmfc_pkg::FMFC_OFF)
    else $error("latched fault not cleared");
  a_hv_recycle: assert property (@(posedge ref_clk) disable iff (reset)
    (LATCHED && next_state == fmfc_pkg::FMFC_FAULT && uvlo) |=> hv_start_enable)
    else $error("start-up generator not enabled in latch");
endmodule

// file: fmfc_power_stage.sv
// Behavioural power switch, sense resistor and auxiliary winding
`timescale 1ns/10ps
module fmfc_power_stage (
  // Clock
  input wire logic ref_clk,
  // Drive and threshold from the controller
  input wire logic gate_out,
  input wire logic [fmfc_pkg::THR_W-1:0] peak_threshold,
  // Output held above the overvoltage level
  input wire logic ovp_force,
  // Comparator levels back to the controller
  output logic current_trip_cmp,
  output logic demag_arm_cmp,
  output logic demag_fall_cmp,
  output logic demag_ovp_cmp
);
  logic [10:0] ramp = 11'h000;
  logic [3:0] ring = 4'h0;
  initial begin
    current_trip_cmp = 1'b0;
    demag_arm_cmp = 1'b0;
    demag_fall_cmp = 1'b0;
    demag_ovp_cmp = 1'b0;
  end
  // Ringing repeats while off, so a missed valley is retried like a starter
  always @(negedge ref_clk) begin
    ramp <= gate_out ? ramp + 11'h040 : 11'h000;
    ring <= gate_out ? 4'h0 : ring + 4'h1;
    current_trip_cmp <= gate_out && ramp > {1'b0, peak_threshold};
    demag_arm_cmp <= !gate_out && ring >= 4'h2 && ring <= 4'h5;
    demag_fall_cmp <= !gate_out && ring >= 4'h8;
    demag_ovp_cmp <= ovp_force && !gate_out;
  end
endmodule

// file: tb.sv
// Self-checking testbench for the flyback mode and fault control block
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic fb_below_entry_cmp = 1'b0;
  logic fb_at_entry_cmp = 1'b1;
  logic fb_above_exit_cmp = 1'b1;
  logic supply_lockout_cmp = 1'b1;
  logic supply_restart_cmp = 1'b0;
  logic supply_turnon_cmp = 1'b0;
  logic hv_start_cmp = 1'b1;
  logic ovp_force = 1'b0;
  logic [fmfc_pkg::THR_W-1:0] feedback_thr = 10'h190;
  logic [fmfc_pkg::THR_W-1:0] cc_limit_level = 10'h12C;
  logic [fmfc_pkg::THR_W-1:0] burst_clamp_level = 10'h064;
  logic [fmfc_pkg::THR_W-1:0] line_offset = 10'h055;
  logic [fmfc_pkg::THR_W-1:0] peak_threshold, sense_offset;
  logic demag_arm_cmp, demag_fall_cmp, demag_ovp_cmp, current_trip_cmp, gate_out;
  logic lowered_lockout_sel, hv_start_enable, fault_active, burst_active, gate_l, hv_l, fault_l;
  int errors = 0;
  int total_checks = 0;
  int n;

  always #12.5 ref_clk = ~ref_clk;

  fmfc_top #(.LATCHED(1'b0), .JITTER_HALF(8)) dut (.ref_clk, .reset, .fb_below_entry_cmp, .fb_at_entry_cmp,
    .fb_above_exit_cmp, .demag_arm_cmp, .demag_fall_cmp, .demag_ovp_cmp, .current_trip_cmp, .supply_lockout_cmp,
    .supply_restart_cmp, .supply_turnon_cmp, .hv_start_cmp, .feedback_thr, .cc_limit_level, .burst_clamp_level,
    .line_offset, .gate_out, .peak_threshold, .sense_offset, .lowered_lockout_sel, .hv_start_enable,
    .fault_active, .burst_active);
  // Latched variant tracks the first one on shared inputs until the fault paths part
  fmfc_top #(.LATCHED(1'b1), .JITTER_HALF(8)) dut2 (.ref_clk, .reset, .fb_below_entry_cmp, .fb_at_entry_cmp,
    .fb_above_exit_cmp, .demag_arm_cmp, .demag_fall_cmp, .demag_ovp_cmp, .current_trip_cmp, .supply_lockout_cmp,
    .supply_restart_cmp, .supply_turnon_cmp, .hv_start_cmp, .feedback_thr, .cc_limit_level, .burst_clamp_level,
    .line_offset, .gate_out(gate_l), .peak_threshold(), .sense_offset(), .lowered_lockout_sel(),
    .hv_start_enable(hv_l), .fault_active(fault_l), .burst_active());
  fmfc_power_stage stage (.ref_clk, .gate_out, .peak_threshold, .ovp_force, .current_trip_cmp, .demag_arm_cmp,
    .demag_fall_cmp, .demag_ovp_cmp);

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    if (errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask

  task automatic wait_gate(input logic v);
    n = 0;
    while (gate_out !== v && n < 200) begin
      cyc(1);
      n++;
    end
    check("gate_wait", gate_out, v);
  endtask

  // Counts cycles with the gate high over a span; lockout and burst must show none
  task automatic gate_quiet(input string name, input int k);
    int hi;
    hi = 0;
    repeat (k) begin
      cyc(1);
      if (gate_out !== 1'b0) hi++;
    end
    check(name, hi, 0);
  endtask

  // Full and 5 percent lowered threshold, each for half of a 16 cycle wave
  task automatic thr_check(input logic [9:0] exp);
    int hi, lo, bad;
    hi = 0;
    lo = 0;
    bad = 0;
    cyc(4);
    repeat (32) begin
      cyc(1);
      if (peak_threshold === exp) hi++;
      else if (peak_threshold === exp - exp * fmfc_pkg::JITTER_PCT / fmfc_pkg::PCT_FULL) lo++;
      else bad++;
    end
    check("thr_full", hi, 16);
    check("thr_low", lo, 16);
    check("thr_other", bad, 0);
  endtask

  task automatic t_start();
    gate_quiet("gate_lockout", 30);
    supply_turnon_cmp = 1'b1;
    supply_lockout_cmp = 1'b0;
    wait_gate(1'b1);
    check("lowered_start", lowered_lockout_sel, 1'b0);
  endtask

  task automatic t_thresholds();
    thr_check(10'h12C);
    feedback_thr = 10'h0C8;
    cc_limit_level = 10'h258;
    thr_check(10'h0C8);
    line_offset = 10'h2AA;
    cyc(3);
    check("sense_offset", sense_offset, 10'h2AA);
  endtask

  // A pin change needs the synchroniser's two edges, so turn-off lands three edges on
  task automatic t_trip();
    wait_gate(1'b0);
    wait_gate(1'b1);
    @(posedge ref_clk);
    while (current_trip_cmp !== 1'b1) @(posedge ref_clk);
    @(posedge ref_clk);
    #1 check("gate_hold_sync", gate_out, 1'b1);
    @(posedge ref_clk);
    #1 check("gate_trip", gate_out, 1'b0);
  endtask

  task automatic t_burst();
    cyc(1);
    fb_above_exit_cmp = 1'b0;
    fb_at_entry_cmp = 1'b0;
    fb_below_entry_cmp = 1'b1;
    cyc(40);
    check("burst_on", burst_active, 1'b1);
    check("lowered_on", lowered_lockout_sel, 1'b1);
    gate_quiet("gate_burst", 40);
    fb_below_entry_cmp = 1'b0;
    fb_at_entry_cmp = 1'b1;
    wait_gate(1'b1);
    check("burst_off", burst_active, 1'b0);
    thr_check(10'h064);
    check("lowered_hold", lowered_lockout_sel, 1'b1);
    fb_above_exit_cmp = 1'b1;
    cyc(4);
    check("lowered_off", lowered_lockout_sel, 1'b0);
  endtask

  // Each pass starts from a fresh off-time, so the sample is set up before the valley
  task automatic trips(input int k, input logic v);
    repeat (k) begin
      wait_gate(1'b1);
      wait_gate(1'b0);
      ovp_force = v;
      wait_gate(1'b1);
    end
    ovp_force = 1'b0;
  endtask

  task automatic t_ovp();
    trips(3, 1'b1);
    check("fault_after3", fault_active, 1'b0);
    trips(1, 1'b0);
    trips(3, 1'b1);
    check("fault_cleared_cnt", fault_active, 1'b0);
    trips(1, 1'b0);
    trips(3, 1'b1);
    wait_gate(1'b0);
    ovp_force = 1'b1;
    cyc(40);
    ovp_force = 1'b0;
    check("fault_on", fault_active, 1'b1);
    check("fault_on_l", fault_l, 1'b1);
    gate_quiet("gate_fault", 40);
    supply_turnon_cmp = 1'b0;
    supply_lockout_cmp = 1'b1;
    cyc(6);
    check("hv_enable_l", hv_l, 1'b1);
    check("hv_enable", hv_start_enable, 1'b1);
    supply_restart_cmp = 1'b1;
    cyc(6);
    supply_restart_cmp = 1'b0;
    supply_lockout_cmp = 1'b0;
    supply_turnon_cmp = 1'b1;
    wait_gate(1'b1);
    check("fault_auto", fault_active, 1'b0);
    check("hv_off_l", hv_l, 1'b0);
    check("hv_off", hv_start_enable, 1'b0);
    check("fault_held_l", fault_l, 1'b1);
    check("gate_held_l", gate_l, 1'b0);
  endtask

  task automatic t_latch_clear();
    hv_start_cmp = 1'b0;
    supply_turnon_cmp = 1'b0;
    supply_lockout_cmp = 1'b1;
    supply_restart_cmp = 1'b1;
    cyc(6);
    check("fault_clear_l", fault_l, 1'b0);
    hv_start_cmp = 1'b1;
    supply_restart_cmp = 1'b0;
    supply_lockout_cmp = 1'b0;
    supply_turnon_cmp = 1'b1;
    n = 0;
    while (gate_l !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    check("gate_resume_l", gate_l, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    cyc(1);
    reset = 1'b0;
    t_start();
    t_thresholds();
    t_trip();
    t_burst();
    t_ovp();
    t_latch_clear();
    close_out();
  end

  // Whole run needs several hundred cycles
  initial begin
    #(25 * 20000);
    errors++;
    close_out();
  end
endmodule
